// ### hdl/pbf_pkg.sv
// Package for the pixel bump and fog stage: register map, fields, types
package pbf_pkg;
    // Register word offsets (byte address = 4 * offset, word index = addr[5:2])
    localparam logic [3:0] REG_FOG_DEPTH_SCALE = 4'h0;
    localparam logic [3:0] REG_TABLE_FOG_COLOUR = 4'h1;
    localparam logic [3:0] REG_VERTEX_FOG_COLOUR = 4'h2;
    localparam logic [3:0] REG_FOG_TABLE_INDEX = 4'h3;
    localparam logic [3:0] REG_FOG_TABLE_DATA = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    // Reset values
    localparam logic [15:0] FOG_SCALE_RESET = 16'h8000;
    localparam logic [23:0] FOG_COLOUR_RESET = 24'h000000;
    // Fog control field codes
    localparam logic [1:0] FOG_TABLE = 2'h0;
    localparam logic [1:0] FOG_VERTEX = 2'h1;
    localparam logic [1:0] FOG_NONE = 2'h2;
    localparam logic [1:0] FOG_TABLE2 = 2'h3;
    // Texture/shading operations
    localparam logic [1:0] TSO_DECAL = 2'h0;
    localparam logic [1:0] TSO_MODULATE = 2'h1;
    localparam logic [1:0] TSO_DECAL_ALPHA = 2'h2;
    localparam logic [1:0] TSO_MODULATE_ALPHA = 2'h3;
    // Fixed-point constants
    localparam logic [7:0] FULL_BYTE = 8'hff;
    localparam logic [8:0] UNITY_STEP = 9'h100;
    localparam logic [7:0] CODE_MAX = 8'hff;
    localparam int TABLE_DEPTH = 128;
    localparam int EXP_BIAS = 8'h00;

    // Shading control word fields that this stage uses
    typedef struct packed {
        logic bump;
        logic [1:0] fog_ctrl;
        logic [1:0] tex_op;
        logic src_sel;
        logic dst_sel;
    } pbf_ctrl_type;

    // Per-polygon light parameter
    typedef struct packed {
        logic [7:0] bias;
        logic [7:0] elev;
        logic [7:0] azim;
        logic [7:0] light_az;
    } pbf_light_type;

    // One incoming pixel
    typedef struct packed {
        pbf_ctrl_type ctrl;
        pbf_light_type light;
        logic [31:0] base;
        logic [31:0] texel;
        logic [7:0] elev_code;
        logic [7:0] azim_code;
        logic [7:0] vtx_fog;
        logic [31:0] depth;
    } pbf_pixel_type;

    // One outgoing pixel
    typedef struct packed {
        logic [31:0] colour;
        logic src_sel;
        logic dst_sel;
    } pbf_out_type;
endpackage

// ### hdl/pbf_trig.sv
// Sine lookup for a quarter turn, 9-bit code in, 8-bit amplitude out
`timescale 1ns/100ps
module pbf_trig
    import pbf_pkg::*;
(
    // Angle code, 0..256 covering a quarter turn
    input wire logic [8:0] quarter_i,
    // Sine scaled so 1.0 = 255
    output logic [7:0] sine_o
);
    logic [7:0] rom [0:256];

    // Table built at elaboration, parabolic approximation of sine
    generate
        for (genvar k = 0; k <= 256; k++) begin : g_rom
            localparam int X = k;
            localparam int V = (X * (512 - X) * 255) / 65536;
            assign rom[k] = 8'(V);
        end
    endgenerate

    assign sine_o = rom[quarter_i];
endmodule

// ### hdl/pbf_stage.sv
// Pixel bump-map brightness and fog stage with Avalon-MM registers
//
// Function
// - Light word: bias 31-24, elevation 23-16, azimuth 15-8, light angle 7-0.
// - Light word comes from third vertex offset colour slot, later ones in strips.
// - Bump texel RGB forced white, alpha is brightness 0x00 dark to 0xFF bright.
// - Elevation code spans 0-90 degrees, azimuth 0-360, code 255 taken as 256.
// - Alpha = bias + elev*sin(s) + azim*cos(s)*cos(r-q), code 255 is 1.0.
// - Bump texel merges with base colour by texture op; decal alpha blends.
// - Destination and source select pick secondary accumulation buffer.
// - Fog enable and mode come from fog control field of control word.
// - Separate table and vertex fog colours, both usable on one screen.
// - Fog is applied before alpha blending.
// - Fogged = (1-f)*pixel + f*fogcolour with 8-bit coefficient f.
// - Table mode holds 128 coefficients, interpolates two chosen by depth.
// - Table depth is depth times density, clamped to 1.0 .. 255.9999; above the range the code takes entry 127 with weight 0.
// - Address bits 6-4 from low exponent bits, 3-0 top mantissa bits.
// - Density is 8-bit mantissa in 15-8 with unity bit, signed exponent 7-0.
// - Entry 0 maps to depth 1.0, entry 127 to depth 256.0.
// - Entry upper byte is own coefficient, lower byte next coefficient.
// - Second table variant replaces base alpha with coeff, RGB with fog colour.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module pbf_stage
    import pbf_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Pixel in from interpolator
    input wire logic pix_valid_i,
    input wire pbf_pixel_type pix_i,
    // Pixel out to blending
    output logic out_valid_o,
    output pbf_out_type out_o
);
    // Software state
    logic [15:0] fog_depth_scale;
    logic [23:0] table_fog_colour;
    logic [23:0] vertex_fog_colour;
    logic [6:0] tbl_index;
    logic [15:0] fog_table [0:TABLE_DEPTH-1];
    logic [31:0] pix_count;
    logic ack;

    // Bus decode
    wire [3:0] word_sel = avs_address_i[5:2];
    wire bus_req = (avs_read_i | avs_write_i) & ~ack;
    // Writes land on the answer edge, where the master sees waitrequest low
    wire wr_go = avs_write_i & ack;
    logic [31:0] rd_mux;

    always_comb begin
        unique case (word_sel)
            REG_FOG_DEPTH_SCALE: rd_mux = {16'h0000, fog_depth_scale};
            REG_TABLE_FOG_COLOUR: rd_mux = {8'h00, table_fog_colour};
            REG_VERTEX_FOG_COLOUR: rd_mux = {8'h00, vertex_fog_colour};
            REG_FOG_TABLE_INDEX: rd_mux = {25'h0000000, tbl_index};
            REG_FOG_TABLE_DATA: rd_mux = {16'h0000, fog_table[tbl_index]};
            REG_STATUS: rd_mux = pix_count;
            default: rd_mux = 32'h00000000; // Unmapped reads as zero
        endcase
    end

    // One wait cycle per access keeps readdata aligned with waitrequest low
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else begin
            ack <= bus_req;
            avs_waitrequest_o <= ~bus_req; // Registered copy of ~ack
            if (bus_req) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    // Register writes; table index auto-increments for fast loading
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fog_depth_scale <= FOG_SCALE_RESET;
            table_fog_colour <= FOG_COLOUR_RESET;
            vertex_fog_colour <= FOG_COLOUR_RESET;
            tbl_index <= 7'h00;
        end else if (wr_go) begin
            unique case (word_sel)
                REG_FOG_DEPTH_SCALE: fog_depth_scale <= avs_writedata_i[15:0];
                REG_TABLE_FOG_COLOUR:
                    table_fog_colour <= avs_writedata_i[23:0];
                REG_VERTEX_FOG_COLOUR:
                    vertex_fog_colour <= avs_writedata_i[23:0];
                REG_FOG_TABLE_INDEX: tbl_index <= avs_writedata_i[6:0];
                REG_FOG_TABLE_DATA: tbl_index <= tbl_index + 7'h01;
                default: ;
            endcase
        end
    end

    // Table storage has no reset; software loads it before use
    always_ff @(posedge clock_i) begin
        if (wr_go && word_sel == REG_FOG_TABLE_DATA) begin
            fog_table[tbl_index] <= avs_writedata_i[15:0];
        end
    end

    // ---------------- Bump brightness ----------------
    // Light word fields as laid out per polygon
    pbf_light_type lw;
    assign lw = pix_i.light;

    // Code 255 stretched to a full step so 90 and 360 degrees are reachable
    wire [8:0] s_ang = (pix_i.elev_code == CODE_MAX) ? UNITY_STEP
                     : {1'b0, pix_i.elev_code};
    wire [8:0] r_ang = (pix_i.azim_code == CODE_MAX) ? UNITY_STEP
                     : {1'b0, pix_i.azim_code};
    wire [8:0] d_ang = r_ang - {1'b0, lw.light_az};
    // Fold the azimuth difference into a quadrant for cosine
    wire [7:0] d_low = d_ang[7:0];
    wire [1:0] quad = d_ang[7:6];
    wire [8:0] cos_arg = quad[0] ? {1'b0, d_low[5:0], 2'b00}
                       : UNITY_STEP - {1'b0, d_low[5:0], 2'b00};
    wire cos_neg = quad[0] ^ quad[1];
    wire [7:0] sin_s;
    wire [7:0] cos_s;
    wire [7:0] cos_d;

    pbf_trig u_sin_s (.quarter_i(s_ang), .sine_o(sin_s));
    pbf_trig u_cos_s (.quarter_i(UNITY_STEP - s_ang), .sine_o(cos_s));
    pbf_trig u_cos_d (.quarter_i(cos_arg), .sine_o(cos_d));

    // Alpha sum in 1/255 units; negative cosine term subtracts
    wire [15:0] t2 = lw.elev * sin_s;
    wire [15:0] cs = cos_s * cos_d;
    wire [23:0] t3 = lw.azim * cs[15:8];
    wire signed [17:0] acc = $signed({10'h000, lw.bias})
        + $signed({10'h000, t2[15:8]})
        + (cos_neg ? -$signed({10'h000, t3[15:8]})
                   : $signed({10'h000, t3[15:8]}));
    wire [7:0] bump_alpha = acc[17] ? 8'h00
        : (acc > 18'sh000ff) ? FULL_BYTE : acc[7:0];
    wire [31:0] texel = pix_i.ctrl.bump ? {bump_alpha, {3{FULL_BYTE}}}
                                        : pix_i.texel;

    // Texture/shading merge with base colour, per channel
    wire [31:0] shaded;
    // Alpha 0xff weighs as a full 256 so both blend end points land exactly
    wire [8:0] t_wgt = {1'b0, texel[31:24]} + {8'h00, texel[31]};
    generate
        for (genvar c = 0; c < 3; c++) begin : g_shade
            wire [7:0] tc = texel[8*c +: 8];
            wire [7:0] bc = pix_i.base[8*c +: 8];
            wire [15:0] mod = tc * bc;
            wire [15:0] mix = tc * t_wgt + bc * (UNITY_STEP - t_wgt);
            assign shaded[8*c +: 8] = (pix_i.ctrl.tex_op == TSO_DECAL) ? tc
                : (pix_i.ctrl.tex_op == TSO_DECAL_ALPHA) ? mix[15:8]
                : mod[15:8];
        end
    endgenerate
    wire [15:0] amod = texel[31:24] * pix_i.base[31:24];
    assign shaded[31:24] = (pix_i.ctrl.tex_op == TSO_MODULATE_ALPHA)
        ? amod[15:8] : (pix_i.ctrl.tex_op == TSO_DECAL) ? texel[31:24]
        : pix_i.base[31:24];

    // ---------------- Table fog address ----------------
    // Product exponent: depth exponent plus signed density exponent
    wire [7:0] z_exp = pix_i.depth[30:23];
    wire [15:0] mprod = {1'b1, pix_i.depth[22:16]} * fog_depth_scale[15:8];
    wire norm = mprod[15];
    wire signed [10:0] e_sum = $signed({3'b000, z_exp}) - 11'sd127
        + $signed({{3{fog_depth_scale[7]}}, fog_depth_scale[7:0]})
        + $signed({10'h000, norm});
    wire [6:0] mfrac = norm ? mprod[14:8] : mprod[13:7];
    wire too_low = e_sum < 11'sd0;
    wire too_high = e_sum > 11'sd7;
    // Entry 0 is depth 1.0, entry 127 the top of the range
    wire [6:0] tbl_addr = too_low ? 7'h00 : too_high ? 7'h7f
        : {e_sum[2:0], mfrac[6:3]};
    wire [2:0] wgt = (too_low | too_high) ? 3'h0 : mfrac[2:0];
    wire [15:0] entry = fog_table[tbl_addr];
    // Interpolate from upper byte toward lower byte
    wire [10:0] f_lo = {3'h0, entry[15:8]} * (4'h8 - {1'b0, wgt});
    wire [10:0] f_hi = {3'h0, entry[7:0]} * {1'b0, wgt};
    wire [11:0] f_sum = f_lo + f_hi;
    wire [7:0] tbl_coeff = f_sum[10:3];

    // ---------------- Fog ----------------
    wire fc_table = pix_i.ctrl.fog_ctrl == FOG_TABLE;
    wire fc_vertex = pix_i.ctrl.fog_ctrl == FOG_VERTEX;
    wire fc_mode2 = pix_i.ctrl.fog_ctrl == FOG_TABLE2;
    wire [7:0] f_coef = fc_vertex ? pix_i.vtx_fog : tbl_coeff;
    wire [23:0] f_col = fc_vertex ? vertex_fog_colour : table_fog_colour;
    // Coefficient 0xff counts as full fog so the fog colour comes out whole
    wire [8:0] f_wgt = {1'b0, f_coef} + {8'h00, f_coef[7]};
    wire [23:0] fogged;
    generate
        for (genvar c = 0; c < 3; c++) begin : g_fog
            wire [15:0] p = shaded[8*c +: 8] * (UNITY_STEP - f_wgt);
            wire [15:0] q = f_col[8*c +: 8] * f_wgt;
            wire [16:0] s = p + q;
            assign fogged[8*c +: 8] = s[15:8];
        end
    endgenerate

    // Fog result goes out before the blender sees the pixel
    logic [31:0] next_colour;
    always_comb begin
        if (fc_mode2) begin
            next_colour = {f_coef, table_fog_colour};
        end else if (fc_table | fc_vertex) begin
            next_colour = {shaded[31:24], fogged};
        end else begin
            next_colour = shaded;
        end
    end

    // Output register, buffer selects passed with the pixel
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_o <= '0;
            pix_count <= 32'h00000000;
        end else begin
            out_valid_o <= pix_valid_i;
            if (pix_valid_i) begin
                out_o <= {next_colour, pix_i.ctrl.src_sel,
                          pix_i.ctrl.dst_sel};
                pix_count <= pix_count + 32'h00000001;
            end
        end
    end

    // ---------------- Assertions ----------------
    a_out_follows_in: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) pix_valid_i |=> out_valid_o)
        else $error("output valid did not follow input");
    a_bump_white: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        pix_valid_i && pix_i.ctrl.bump && pix_i.ctrl.tex_op == TSO_DECAL
        && pix_i.ctrl.fog_ctrl == FOG_NONE
        |=> out_o.colour[23:0] == 24'hffffff)
        else $error("bump texel not white");
    a_bump_brightest: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        pix_valid_i && pix_i.ctrl.bump
        && pix_i.ctrl.tex_op == TSO_DECAL_ALPHA
        && pix_i.light.bias == CODE_MAX && pix_i.light.elev == 8'h00
        && pix_i.light.azim == 8'h00 && pix_i.ctrl.fog_ctrl == FOG_NONE
        |=> out_o.colour[23:0] == 24'hffffff)
        else $error("brightest bump texel not white under decal alpha");
    a_dst_select: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        pix_valid_i |=> out_o.dst_sel == $past(pix_i.ctrl.dst_sel))
        else $error("destination select lost");
    a_mode2_colour: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        pix_valid_i && fc_mode2 |=> out_o.colour[23:0] == table_fog_colour)
        else $error("mode 2 colour not fog colour");
    a_bus_answer: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
        else $error("bus answer late");
    c_bump: cover property (@(posedge clock_i) pix_valid_i && pix_i.ctrl.bump);
    c_table: cover property (@(posedge clock_i) pix_valid_i && fc_table);
    c_mode2: cover property (@(posedge clock_i) pix_valid_i && fc_mode2);
endmodule

// ### tb/pbf_pixel_model.sv
// Upstream interpolator model: presents one pixel per request
`timescale 1ns/100ps
module pbf_pixel_model
    import pbf_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Pixel toward the stage
    output logic pix_valid_o,
    output pbf_pixel_type pix_o
);
    // Idle at time zero
    initial begin
        pix_valid_o = 1'b0;
        pix_o = '0;
    end

    // One-beat pixel; once released the fields show inverted data so a
    // stale pixel can never pass for a fresh one
    task automatic send(input pbf_pixel_type p);
        @(posedge clock_i);
        pix_valid_o <= 1'b1;
        pix_o <= p;
        @(posedge clock_i);
        pix_valid_o <= 1'b0;
        pix_o <= ~p;
    endtask
endmodule

// ### tb/pbf_stage_tb.sv
// Self-checking bench for the pixel bump and fog stage
`timescale 1ns/100ps
module pbf_stage_tb
    import pbf_pkg::*;
;
    logic clock_i;
    logic rst_n_i;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_wdata;
    logic [31:0] avs_rdata;
    logic avs_wait;
    logic pix_valid;
    pbf_pixel_type pix;
    logic out_valid;
    pbf_out_type out_px;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 69;
    int n_pix = 0;
    logic [31:0] rd;

    pbf_stage uut (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .avs_address_i(avs_address),
        .avs_read_i(avs_read),
        .avs_write_i(avs_write),
        .avs_writedata_i(avs_wdata),
        .avs_readdata_o(avs_rdata),
        .avs_waitrequest_o(avs_wait),
        .pix_valid_i(pix_valid),
        .pix_i(pix),
        .out_valid_o(out_valid),
        .out_o(out_px)
    );

    pbf_pixel_model model (
        .clock_i(clock_i),
        .pix_valid_o(pix_valid),
        .pix_o(pix)
    );

    // 125 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // Hang guard: a few hundred cycles are needed, far below this
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            $display("BAD %0t timeout", $time);
            conclude();
        end
    end

    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Byte address of a register word
    function automatic logic [5:0] ra(input logic [3:0] r);
        return {r, 2'b00};
    endfunction

    // Bus access held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge clock_i);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_wdata <= d;
        do @(posedge clock_i); while (avs_wait !== 1'b0);
        rd = avs_rdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Pixel with random select bits, angles and positive depth
    function automatic pbf_pixel_type mk(input logic bump,
            input logic [1:0] fog, input logic [31:0] light,
            input logic [31:0] b, input logic [31:0] tx);
        pbf_pixel_type q;
        q = '0;
        q.ctrl.bump = bump;
        q.ctrl.fog_ctrl = fog;
        q.ctrl.tex_op = TSO_DECAL_ALPHA;
        q.ctrl.src_sel = 1'($random(seed));
        q.ctrl.dst_sel = 1'($random(seed));
        q.light = light;
        q.base = b;
        q.texel = tx;
        q.elev_code = 8'($random(seed));
        q.azim_code = 8'($random(seed));
        q.vtx_fog = 8'($random(seed));
        q.depth = {2'b00, 30'($random(seed))};
        return q;
    endfunction

    // Result is registered on the same edge that takes the pixel and checked 1 ns later
    task automatic run(input pbf_pixel_type q, output pbf_out_type o);
        model.send(q);
        #1;
        check({31'h0, out_valid}, 32'h1, "out valid");
        o = out_px;
        n_pix++;
    endtask

    // Main sequence
    initial begin
        int i;
        logic [23:0] tcol;
        logic [31:0] base;
        logic [31:0] texw;
        pbf_pixel_type p;
        pbf_out_type o;
        rst_n_i = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_wdata = 32'h0;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        bus(1'b0, ra(REG_FOG_DEPTH_SCALE), 32'h0);
        check(rd, {16'h0, FOG_SCALE_RESET}, "scale reset");
        bus(1'b0, ra(REG_TABLE_FOG_COLOUR), 32'h0);
        check(rd, {8'h0, FOG_COLOUR_RESET}, "colour reset");
        bus(1'b1, 6'h3c, 32'hffffffff);
        bus(1'b0, 6'h3c, 32'h0);
        check(rd, 32'h0, "unmapped");
        tcol = 24'($random(seed));
        bus(1'b1, ra(REG_TABLE_FOG_COLOUR), {8'h00, tcol});
        bus(1'b1, ra(REG_VERTEX_FOG_COLOUR), {8'h00, ~tcol});
        bus(1'b0, ra(REG_TABLE_FOG_COLOUR), 32'h0);
        check(rd, {8'h00, tcol}, "table colour");
        bus(1'b0, ra(REG_VERTEX_FOG_COLOUR), 32'h0);
        check(rd, {8'h00, ~tcol}, "vertex colour");
        bus(1'b1, ra(REG_FOG_DEPTH_SCALE), 32'h0000ff07);
        bus(1'b0, ra(REG_FOG_DEPTH_SCALE), 32'h0);
        check(rd, 32'h0000ff07, "scale");
        // Flat table: any depth and any weight must give the same value
        bus(1'b1, ra(REG_FOG_TABLE_INDEX), 32'h0);
        for (i = 0; i < TABLE_DEPTH; i++)
            bus(1'b1, ra(REG_FOG_TABLE_DATA), 32'h00005a5a);
        bus(1'b1, ra(REG_FOG_TABLE_INDEX), 32'h7f);
        bus(1'b0, ra(REG_FOG_TABLE_DATA), 32'h0);
        check(rd, 32'h00005a5a, "table entry");
        // Second table variant: alpha becomes coefficient, RGB fog colour
        for (i = 0; i < 16; i++) begin
            p = mk(1'b0, FOG_TABLE2, $random(seed), $random(seed),
                   {8'h5a, tcol});
            run(p, o);
            check(o.colour, {8'h5a, tcol}, "fog mode 2");
            check({30'h0, o.src_sel, o.dst_sel},
                  {30'h0, p.ctrl.src_sel, p.ctrl.dst_sel}, "sel");
        end
        // Bump with bias alone: full bias or decal op is white, zero bias under decal alpha keeps base RGB
        for (i = 0; i < 16; i++) begin
            base = $random(seed);
            p = mk(1'b1, FOG_NONE, {i[0] ? CODE_MAX : 8'h00, 16'h0,
                   8'($random(seed))}, base, $random(seed));
            p.ctrl.tex_op = i[1] ? TSO_DECAL : TSO_DECAL_ALPHA;
            run(p, o);
            check({8'h0, o.colour[23:0]}, {8'h0, (i[0] | i[1])
                  ? 24'hffffff : base[23:0]}, "bump");
        end
        // Per-vertex fog at its end points: clear pixel, then fog colour
        for (i = 0; i < 16; i++) begin
            texw = $random(seed);
            p = mk(1'b0, FOG_VERTEX, $random(seed), $random(seed), texw);
            p.ctrl.tex_op = TSO_DECAL;
            p.vtx_fog = i[0] ? FULL_BYTE : 8'h00;
            run(p, o);
            check(o.colour, {texw[31:24], i[0] ? ~tcol : texw[23:0]},
                  "vertex fog");
        end
        bus(1'b0, ra(REG_STATUS), 32'h0);
        check(rd, 32'(n_pix), "pixel count");
        conclude();
    end
endmodule
